// ### src/arx_receiver.sv
// Summary of operation
// (R1) Idle falling edge on line starts character
// (R2) Remote sends start bit as low
// (R3) Half bit later, confirm line still low
// (R4) High at mid-start: abandon silently, rewatch edge
// (R5) Full bit steps, majority vote per bit
// (R6) Shift voted bits until all data collected
// (R7) Stop bit low sets framing error
// (R8) Completed character queued, pending flag set
// (R9) Data read returns oldest, removes it
// (R10) After overrun, no reception until cleared
// (R11) Pending while enabled and queue nonempty
// (R12) Pending flag read-only to software
// (R13) Data interrupt needs all three enables
// (R14) Pending flag ignores interrupt enables
// (R15) Sixteen-times oversampling, shift once per bit
// (R16) Queue holds two complete characters
// (R17) Eight/nine bits, LSB first, start/stop framing
// (R18) Receive only when enabled, async, port on
// (R19) Full queue on completion: overrun, discard
`timescale 1ns/1ps
`default_nettype none

module arx_receiver
  import arx_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        rx_line,
  output var  logic        rx_pending_flag,
  output var  logic        rx_irq,
  output var  logic        irq
);

  typedef struct packed {
    logic [CTRL_WIDTH-1:0] ctrl;
    logic [15:0]           baud_div;
    logic [EV_WIDTH-1:0]   irq_stat;
    logic [EV_WIDTH-1:0]   irq_mask;
    logic                  overrun;
    logic                  sync1;
    logic                  sync2;
    logic                  line_prev;
    logic [15:0]           baud_cnt;
    logic [3:0]            phase;
    logic [3:0]            bit_cnt;
    logic [8:0]            rx_shift_reg;
    logic [1:0]            votes;
    arx_state_t            state;
    logic                  pready;
    logic [31:0]           prdata;
    logic                  pslverr;
    logic                  rx_pending_flag;
    logic                  rx_irq;
    logic                  irq;
  } arx_regs_t;

  arx_regs_t r;
  arx_regs_t next_r;

  logic              push;
  logic [CHAR_W-1:0] push_data;
  logic              pop;
  logic              fifo_full;
  logic              fifo_empty;
  logic [1:0]        fifo_count;
  logic [CHAR_W-1:0] head_data;

  // ----------------------------------------------------------------
  // Receive queue
  // ----------------------------------------------------------------
  arx_fifo arx_fifo_i (
    .pclk      (pclk),
    .presetn   (presetn),
    .push      (push),
    .push_data (push_data),
    .pop       (pop),
    .full      (fifo_full),
    .empty     (fifo_empty),
    .count     (fifo_count),
    .head_data (head_data)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic                rx_en;
    logic                tick;
    logic                vote;
    logic                setup;
    logic                done;
    logic                hit;
    logic [31:0]         rdata;
    logic [3:0]          last_idx;
    logic [8:0]          data9;
    logic [EV_WIDTH-1:0] ev;
    logic [EV_WIDTH-1:0] clr;
    logic                ovr_clr;
    rx_en     = 1'b0;
    tick      = 1'b0;
    vote      = 1'b0;
    setup     = 1'b0;
    done      = 1'b0;
    hit       = 1'b0;
    rdata     = '0;
    last_idx  = LAST_IDX_8;
    data9     = '0;
    ev        = '0;
    clr       = '0;
    ovr_clr   = 1'b0;
    next_r    = r;
    push      = 1'b0;
    push_data = '0;
    pop       = 1'b0;

    rx_en = r.ctrl[CTRL_RX_ON_BIT] & ~r.ctrl[CTRL_SYNC_BIT] & r.ctrl[CTRL_PORT_ON_BIT]; // (R18)
    last_idx = r.ctrl[CTRL_NINE_BIT] ? LAST_IDX_9 : LAST_IDX_8; // (R17)

    // --------------------------------------------------------------
    // Line synchroniser and oversampling tick
    // --------------------------------------------------------------
    next_r.sync1     = rx_line;
    next_r.sync2     = r.sync1;
    next_r.line_prev = r.sync2;
    if (r.baud_cnt == r.baud_div) begin
      next_r.baud_cnt = '0;
      tick            = 1'b1; // (R15)
    end else begin
      next_r.baud_cnt = r.baud_cnt + 16'h0001;
    end
    // Third sample is the live line at the bit centre
    vote = (r.votes[0] & r.votes[1]) | (r.votes[0] & r.sync2) | (r.votes[1] & r.sync2); // (R5)

    // --------------------------------------------------------------
    // Character recovery
    // --------------------------------------------------------------
    case (r.state)
      ST_IDLE: begin
        // Needs a high-to-low step, so a line stuck low never retriggers
        if (rx_en && !r.overrun && r.line_prev && !r.sync2) begin // (R1) (R10)
          next_r.state    = ST_START;
          next_r.baud_cnt = '0;
          next_r.phase    = '0;
        end
      end
      ST_START: begin
        if (tick) begin
          next_r.phase = r.phase + 4'h1;
          if (r.phase == HALF_BIT_LAST) begin // (R3)
            next_r.phase = '0;
            if (r.sync2) begin
              next_r.state = ST_IDLE; // (R4)
            end else begin
              next_r.state   = ST_DATA;
              next_r.bit_cnt = '0;
            end
          end
        end
      end
      ST_DATA: begin
        if (tick) begin
          next_r.phase = r.phase + 4'h1;
          if (r.phase == VOTE_A) begin
            next_r.votes[0] = r.sync2;
          end
          if (r.phase == VOTE_B) begin
            next_r.votes[1] = r.sync2;
          end
          if (r.phase == BIT_LAST) begin
            next_r.rx_shift_reg = {vote, r.rx_shift_reg[8:1]}; // (R6) (R17)
            next_r.bit_cnt      = r.bit_cnt + 4'h1;
            if (r.bit_cnt == last_idx) begin
              next_r.state = ST_STOP;
            end
          end
        end
      end
      ST_STOP: begin
        if (tick) begin
          next_r.phase = r.phase + 4'h1;
          if (r.phase == VOTE_A) begin
            next_r.votes[0] = r.sync2;
          end
          if (r.phase == VOTE_B) begin
            next_r.votes[1] = r.sync2;
          end
          if (r.phase == BIT_LAST) begin
            next_r.state = ST_IDLE;
            data9 = r.ctrl[CTRL_NINE_BIT] ? r.rx_shift_reg : {1'b0, r.rx_shift_reg[8:1]};
            if (fifo_full) begin
              ev[EV_OVR_BIT] = 1'b1; // (R19)
            end else begin
              push      = 1'b1; // (R8) (R16)
              push_data = {~vote, data9}; // (R7)
              ev[EV_CHAR_BIT] = 1'b1;
              ev[EV_FERR_BIT] = ~vote;
            end
          end
        end
      end
      default: begin
        next_r.state = ST_IDLE;
      end
    endcase
    // Dropping the enable kills a half-received character
    if (!rx_en) begin
      next_r.state = ST_IDLE; // (R18)
    end

    // --------------------------------------------------------------
    // APB slave: one wait state, answer registered
    // --------------------------------------------------------------
    setup = psel & penable & ~r.pready;
    done  = psel & penable & r.pready;
    hit   = 1'b1;
    case (paddr)
      ADDR_CTRL: rdata = 32'(r.ctrl);
      ADDR_BAUD: rdata = 32'(r.baud_div);
      ADDR_STATUS: begin
        rdata[STAT_PEND_BIT] = rx_en & ~fifo_empty; // (R11) (R14)
        rdata[STAT_OVR_BIT]  = r.overrun;
        rdata[STAT_BUSY_BIT] = (r.state != ST_IDLE);
        rdata[STAT_FERR_BIT] = head_data[CHAR_W-1];
        rdata[STAT_CNT_LSB +: 2] = fifo_count;
      end
      ADDR_DATA:     rdata = 32'(head_data); // (R9)
      ADDR_IRQ_STAT: rdata = 32'(r.irq_stat);
      ADDR_IRQ_MASK: rdata = 32'(r.irq_mask);
      default: begin
        hit   = 1'b0;
        rdata = '0;
      end
    endcase
    next_r.pready  = setup;
    next_r.prdata  = (setup && !pwrite) ? rdata : 32'h0000_0000;
    next_r.pslverr = setup & ~hit;

    if (done && pwrite) begin
      case (paddr)
        ADDR_CTRL:     next_r.ctrl     = pwdata[CTRL_WIDTH-1:0];
        ADDR_BAUD:     next_r.baud_div = pwdata[15:0];
        ADDR_IRQ_MASK: next_r.irq_mask = pwdata[EV_WIDTH-1:0];
        ADDR_IRQ_STAT: clr             = pwdata[EV_WIDTH-1:0];
        // Only the overrun bit is writable here; pending stays hardware-owned
        ADDR_STATUS:   ovr_clr         = pwdata[STAT_OVR_BIT]; // (R12)
        default: begin
          clr = '0;
        end
      endcase
    end
    if (done && !pwrite && paddr == ADDR_DATA) begin
      pop = ~fifo_empty; // (R9)
    end

    // --------------------------------------------------------------
    // Sticky flags: a new event beats a same-cycle clear
    // --------------------------------------------------------------
    next_r.overrun  = (r.overrun & ~ovr_clr) | ev[EV_OVR_BIT]; // (R10)
    next_r.irq_stat = (r.irq_stat & ~clr) | ev;
    next_r.irq      = |(next_r.irq_stat & next_r.irq_mask);
    next_r.rx_pending_flag = rx_en & ~fifo_empty; // (R11) (R14)
    next_r.rx_irq = next_r.rx_pending_flag & r.ctrl[CTRL_RXIE_BIT]
                  & r.ctrl[CTRL_PERIPH_IE_BIT] & r.ctrl[CTRL_GLOBAL_IE_BIT]; // (R13)
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r           <= '0;
      r.ctrl      <= CTRL_RST;
      r.baud_div  <= BAUD_DIV_RST;
      r.irq_mask  <= IRQ_MASK_RST;
      r.sync1     <= 1'b1;
      r.sync2     <= 1'b1;
      r.line_prev <= 1'b1;
      r.state     <= ST_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign prdata          = r.prdata;
  assign pready          = r.pready;
  assign pslverr         = r.pslverr;
  assign rx_pending_flag = r.rx_pending_flag;
  assign rx_irq          = r.rx_irq;
  assign irq             = r.irq;

endmodule

`default_nettype wire

// ### src/arx_pkg.sv
package arx_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_BAUD      = 8'h04;
  localparam logic [7:0] ADDR_STATUS    = 8'h08;
  localparam logic [7:0] ADDR_DATA      = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h14;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_RX_ON_BIT     = 0;
  localparam int CTRL_SYNC_BIT      = 1;
  localparam int CTRL_PORT_ON_BIT   = 2;
  localparam int CTRL_NINE_BIT      = 3;
  localparam int CTRL_RXIE_BIT      = 4;
  localparam int CTRL_PERIPH_IE_BIT = 5;
  localparam int CTRL_GLOBAL_IE_BIT = 6;
  localparam int CTRL_WIDTH      = 7;

  // ----------------------------------------------------------------
  // Status and interrupt fields
  // ----------------------------------------------------------------
  localparam int STAT_PEND_BIT   = 0;
  localparam int STAT_OVR_BIT    = 1;
  localparam int STAT_BUSY_BIT   = 2;
  localparam int STAT_FERR_BIT   = 3;
  localparam int STAT_CNT_LSB    = 4;
  localparam int EV_CHAR_BIT     = 0;
  localparam int EV_FERR_BIT     = 1;
  localparam int EV_OVR_BIT      = 2;
  localparam int EV_WIDTH        = 3;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [6:0]  CTRL_RST       = 7'h00;
  localparam logic [15:0] BAUD_DIV_RST   = 16'h0035;
  localparam logic [2:0]  IRQ_MASK_RST   = 3'h0;
  localparam int          OVERSAMPLE     = 16;
  localparam logic [3:0]  HALF_BIT_LAST  = 4'(OVERSAMPLE / 2 - 1);
  localparam logic [3:0]  BIT_LAST       = 4'(OVERSAMPLE - 1);
  localparam logic [3:0]  VOTE_A         = 4'(OVERSAMPLE - 3);
  localparam logic [3:0]  VOTE_B         = 4'(OVERSAMPLE - 2);
  localparam logic [3:0]  LAST_IDX_8     = 4'h7;
  localparam logic [3:0]  LAST_IDX_9     = 4'h8;
  localparam int          CHAR_W         = 10;
  localparam int          FIFO_DEPTH     = 2;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_START = 4'b0010,
    ST_DATA  = 4'b0100,
    ST_STOP  = 4'b1000
  } arx_state_t;

endpackage

// ### src/arx_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module arx_fifo
  import arx_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              push,
  input  wire logic [CHAR_W-1:0] push_data,
  input  wire logic              pop,
  output var  logic              full,
  output var  logic              empty,
  output var  logic [1:0]        count,
  output var  logic [CHAR_W-1:0] head_data
);

  typedef struct packed {
    logic [FIFO_DEPTH-1:0][CHAR_W-1:0] mem;
    logic                              wr_ptr;
    logic                              rd_ptr;
    logic [1:0]                        count;
    logic [CHAR_W-1:0]                 head;
  } arx_fifo_t;

  arx_fifo_t r;
  arx_fifo_t next_r;

  // ----------------------------------------------------------------
  // Two-entry queue, head word kept in a register
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    if (pop && r.count != 2'd0) begin
      next_r.rd_ptr = ~r.rd_ptr;
    end
    if (push && r.count != 2'(FIFO_DEPTH)) begin
      next_r.mem[r.wr_ptr] = push_data;
      next_r.wr_ptr        = ~r.wr_ptr;
    end
    next_r.count = r.count
                 + 2'(push && r.count != 2'(FIFO_DEPTH))
                 - 2'(pop && r.count != 2'd0);
    // Head registered so the bus sees a flop, not a read mux
    next_r.head = (next_r.count == 2'd0) ? '0 : next_r.mem[next_r.rd_ptr];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign full      = (r.count == 2'(FIFO_DEPTH));
  assign empty     = (r.count == 2'd0);
  assign count     = r.count;
  assign head_data = r.head;

endmodule

`default_nettype wire

// ### test/arx_receiver_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module arx_receiver_asserts
  import arx_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic        rx_pending_flag,
  input  wire logic        rx_irq
);
  // ----------------------------------------------------------------
  // Bus answer timing
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  setup_answer_a: assert property ((psel && !penable) |-> ##2 pready)
    else $error("answer not two cycles after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  ready_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("ready without access phase");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  err_unmapped_a: assert property (pslverr |-> (paddr > ADDR_IRQ_MASK || paddr[1:0] != 2'h0))
    else $error("error on mapped address");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");

  // ----------------------------------------------------------------
  // Pending flag and interrupt
  // ----------------------------------------------------------------
  // Flag only drops through a data pop or a control write, never by itself
  pend_drop_a: assert property ($fell(rx_pending_flag) |-> $past(pready) || $past(pready, 2) || $past(pready, 3))
    else $error("pending dropped without bus access");
  irq_pending_a: assert property (rx_irq |-> rx_pending_flag || $past(rx_pending_flag))
    else $error("receive interrupt without pending character");
endmodule

bind arx_receiver arx_receiver_asserts arx_receiver_asserts_i (
  .pclk            (pclk),
  .presetn         (presetn),
  .psel            (psel),
  .penable         (penable),
  .paddr           (paddr),
  .prdata          (prdata),
  .pready          (pready),
  .pslverr         (pslverr),
  .rx_pending_flag (rx_pending_flag),
  .rx_irq          (rx_irq)
);

`default_nettype wire

// ### test/arx_line_model.sv
`timescale 1ns/1ps
`default_nettype none

module arx_line_model
(
  input  wire logic pclk,
  output var  logic rx_line
);
  // ----------------------------------------------------------------
  // Remote transmitter, bit time in pclk cycles
  // ----------------------------------------------------------------
  int bit_len = 32;

  initial rx_line = 1'b1;

  // Caller enters just after a rising edge; idle gap lets the receiver finish
  task automatic send(input logic [8:0] d, input int nb, input logic stop);
    int i;
    rx_line <= 1'b0;
    repeat (bit_len) @(posedge pclk);
    for (i = 0; i < nb; i++) begin
      rx_line <= d[i];
      repeat (bit_len) @(posedge pclk);
    end
    rx_line <= stop;
    repeat (bit_len) @(posedge pclk);
    rx_line <= 1'b1;
    repeat (10) @(posedge pclk);
  endtask

  // Short low pulse, shorter than half a bit
  task automatic glitch(input int n);
    rx_line <= 1'b0;
    repeat (n) @(posedge pclk);
    rx_line <= 1'b1;
    repeat (bit_len) @(posedge pclk);
  endtask
endmodule

`default_nettype wire

// ### test/arx_receiver_tb.sv
`timescale 1ns/1ps
`default_nettype none

module arx_receiver_tb
  import arx_pkg::*;
;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_line;
  logic        rx_pending_flag;
  logic        rx_irq;
  logic        irq;
  logic [31:0] rdv;
  logic        rerr;
  int          n_fail     = 0;
  int          num_checks = 0;

  always #5 pclk = ~pclk;

  arx_receiver arx_receiver_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_line(rx_line), .rx_pending_flag(rx_pending_flag), .rx_irq(rx_irq), .irq(irq));

  arx_line_model arx_line_model_i (.pclk(pclk), .rx_line(rx_line));

  // ----------------------------------------------------------------
  // Checks and bus cycles
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Wait on ready is bounded; a missing answer counts once as a mismatch
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n == 20) chk(32'h0, 32'h1);
    rdv = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_BAUD, 32'h35);
    rd(ADDR_IRQ_MASK, 32'h0);
    rd(8'h18, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    apb(1'b1, ADDR_BAUD, 32'h1);
    apb(1'b1, ADDR_IRQ_MASK, 32'h7);
    apb(1'b1, ADDR_CTRL, 32'h35);
    arx_line_model_i.send(9'h0A5, 8, 1'b1);
    apb(1'b1, ADDR_STATUS, 32'h1);
    chk({29'h0, rx_pending_flag, rx_irq, irq}, 32'h5);
    apb(1'b1, ADDR_CTRL, 32'h75);
    @(posedge pclk);
    chk({31'h0, rx_irq}, 32'h1);
    arx_line_model_i.send(9'h03C, 8, 1'b0);
    arx_line_model_i.send(9'h00F, 8, 1'b1);
    rd(ADDR_STATUS, 32'h23);
    rd(ADDR_DATA, 32'hA5);
    arx_line_model_i.send(9'h055, 8, 1'b1);
    rd(ADDR_STATUS, 32'h1B);
    rd(ADDR_DATA, 32'h23C);
    rd(ADDR_DATA, 32'h0);
    chk({30'h0, rx_pending_flag, rx_irq}, 32'h0);
    rd(ADDR_STATUS, 32'h2);
    apb(1'b1, ADDR_STATUS, 32'h2);
    arx_line_model_i.glitch(8);
    rd(ADDR_STATUS, 32'h0);
    rd(ADDR_IRQ_STAT, 32'h7);
    apb(1'b1, ADDR_IRQ_STAT, 32'h7);
    rd(ADDR_IRQ_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h7D);
    arx_line_model_i.send(9'h1C3, 9, 1'b1);
    rd(ADDR_DATA, 32'h1C3);
    apb(1'b1, ADDR_CTRL, 32'h79);
    arx_line_model_i.send(9'h012, 8, 1'b1);
    rd(ADDR_STATUS, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h37);
    arx_line_model_i.send(9'h012, 8, 1'b1);
    rd(ADDR_STATUS, 32'h0);
    close_out();
  end
endmodule

`default_nettype wire
